// [src/psp_params.svh]
`ifndef PSP_PARAMS_SVH
`define PSP_PARAMS_SVH

// Clock
`define PSP_CLK_PERIOD_PS    4000
// Strobe spacing the port must keep up with
`define PSP_STROBE_GAP_NS    400
`define PSP_STROBE_GAP_CYC   ((`PSP_STROBE_GAP_NS * 1000) / `PSP_CLK_PERIOD_PS)
// Longest time the fault line may stay low after a reinit request
`define PSP_FAULT_HOLD_NS    120
`define PSP_FAULT_HOLD_CYC   ((`PSP_FAULT_HOLD_NS * 1000) / `PSP_CLK_PERIOD_PS)

// Strobe lane positions
`define PSP_STB_WHEEL        0
`define PSP_STB_CARR         1
`define PSP_STB_PAPER        2
`define PSP_STB_RIBBON       3
`define PSP_STB_W            4

// Command word
`define PSP_DATA_W           12
`define PSP_WHEEL_W          7
`define PSP_RIB_LSB          8
`define PSP_RIB_MSB          10
`define PSP_RIB_OFFSET       4'h2
`define PSP_RIB_FIXED        4'h4
`define PSP_UNITS_W          4

// Synchroniser reset level for idle-high lines
`define PSP_IDLE_LEVEL       1'b1

`endif

// [src/psp_pkg.sv]
package psp_pkg;

  // Print wheel cycle, Gray along idle -> move -> strike
  typedef enum logic [1:0] {
    PSP_W_IDLE   = 2'b00,
    PSP_W_MOVE   = 2'b01,
    PSP_W_STRIKE = 2'b11
  } psp_wheel_state_t;

endpackage : psp_pkg

// [src/psp_sync.sv]
`timescale 1ns/1ps
module psp_sync #(
  parameter int   WIDTH   = 1,
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_reg;

  if (WIDTH < 1) begin : g_width_check
    $error("psp_sync: WIDTH must be at least 1");
  end

  // First stage feeds only the second stage
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      meta_reg <= {WIDTH{RST_VAL}};
      q        <= {WIDTH{RST_VAL}};
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule : psp_sync

// [src/psp_port.sv]
`timescale 1ns/1ps
`include "psp_params.svh"

// What this block does
// - Ribbon code on bits 8-10 is units-2
// - Proportional ribbon advance only with option selected
// - Ready outputs driven only while selected
// - Printer ready is power; option ready is not option_busy; others accept-ready
// - Wheel/carriage failure: fault low, halt, drop carriage/paper/wheel readies
// - Fault latched until reinit or power cycle
// - Paper-empty low when sensor fitted and empty
// - Lid-open low when switch fitted and open
// - Ribbon-exhausted low when sensor fitted, used up
// - Data captured only with its own strobe
// - Ribbon command makes wheel report busy
// - Strobes 400 ns apart must be accepted; a strobe to a lane that is not yet ready is dropped
// - Execute in strobe order; motions may overlap
// - Hammer fires only at rest; motion deferred
// - Carriage then wheel: move together, then strike
// - Wheel then carriage: strike first, then carriage
// - All host interface lines are active low; mechanism and sensor lines are active high
module psp_port #(
  parameter logic [`PSP_UNITS_W-1:0] FIXED_RIB_UNITS = `PSP_RIB_FIXED
) (
  input  wire logic                     mclk,
  input  wire logic                     rst,
  // Host pins, all active low
  input  wire logic [`PSP_STB_W-1:0]    strobe_n,
  input  wire logic [`PSP_DATA_W-1:0]   data_n,
  input  wire logic                     select_n,
  input  wire logic                     ribbon_raise_n,
  input  wire logic                     reinit_n,
  output logic                          printer_ready_n,
  output logic                          carriage_ready_n,
  output logic                          paper_ready_n,
  output logic                          wheel_ready_n,
  output logic                          option_ready_n,
  output logic                          fault_n,
  output logic                          paper_empty_n,
  output logic                          lid_open_n,
  output logic                          ribbon_exhausted_n,
  // Configuration and sensors
  input  wire logic                     power_good,
  input  wire logic                     ribbon_option_two,
  input  wire logic                     strike_force_option,
  input  wire logic                     paper_sensor_fitted,
  input  wire logic                     cover_switch_fitted,
  input  wire logic                     ribbon_sensor_fitted,
  input  wire logic                     paper_out,
  input  wire logic                     cover_open,
  input  wire logic                     ribbon_exhausted_flag,
  input  wire logic                     option_busy,
  // Mechanism side
  output logic                          wheel_go,
  output logic [`PSP_WHEEL_W-1:0]       wheel_pos,
  input  wire logic                     wheel_done,
  output logic                          carr_go,
  output logic [`PSP_DATA_W-1:0]        carr_cmd,
  input  wire logic                     carr_done,
  output logic                          paper_go,
  output logic [`PSP_DATA_W-1:0]        paper_cmd,
  input  wire logic                     paper_done,
  output logic                          ribbon_go,
  output logic [`PSP_UNITS_W-1:0]       ribbon_units,
  input  wire logic                     ribbon_done,
  output logic                          hammer_fire,
  input  wire logic                     hammer_done,
  input  wire logic                     motion_fail,
  output logic                          restore_go,
  output logic                          ribbon_raise
);

  if (FIXED_RIB_UNITS < `PSP_RIB_OFFSET) begin : g_rib_check
    $error("psp_port: fixed ribbon advance below 2");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [`PSP_STB_W-1:0]  stb_s;
  logic [`PSP_DATA_W-1:0] data_s;
  logic                   sel_s;
  logic                   raise_s;
  logic                   reinit_s;

  psp_sync #(
    .WIDTH   (`PSP_STB_W + `PSP_DATA_W + 3),
    .RST_VAL (`PSP_IDLE_LEVEL)
  ) u_sync (
    .mclk (mclk),
    .rst  (rst),
    .d    ({strobe_n, data_n, select_n, ribbon_raise_n, reinit_n}),
    .q    ({stb_s, data_s, sel_s, raise_s, reinit_s})
  );

  ////////////////////////////////////////////////////////////////////////////
  // Edge detection on true levels

  logic [`PSP_STB_W-1:0] stb_prev_reg;
  logic                  reinit_prev_reg;
  logic [`PSP_STB_W-1:0] stb_rise;
  logic                  reinit_rise;
  logic [`PSP_DATA_W-1:0] cmd_word;
  logic                  selected;

  // Active low lines carry true at low level
  // invert all lines
  assign cmd_word    = ~data_s;
  assign selected    = ~sel_s;
  assign stb_rise    = ~stb_s & ~stb_prev_reg;
  assign reinit_rise = ~reinit_s & ~reinit_prev_reg;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      stb_prev_reg    <= {`PSP_STB_W{1'b1}};
      reinit_prev_reg <= 1'b1;
    end else begin
      stb_prev_reg    <= ~stb_s;
      reinit_prev_reg <= ~reinit_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fault latch

  logic fault_reg;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      fault_reg <= 1'b0;
    end else if (motion_fail) begin
      fault_reg <= 1'b1;
    end else if (reinit_rise) begin
      fault_reg <= 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      restore_go <= 1'b0;
    end else begin
      restore_go <= reinit_rise;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Holding registers

  logic                      wheel_pend_reg;
  logic                      carr_pend_reg;
  logic                      paper_pend_reg;
  logic                      rib_pend_reg;
  logic [`PSP_WHEEL_W-1:0]   wheel_hold_reg;
  logic [`PSP_DATA_W-1:0]    carr_hold_reg;
  logic [`PSP_DATA_W-1:0]    paper_hold_reg;
  logic [`PSP_UNITS_W-1:0]   rib_hold_reg;
  logic                      wheel_moving_reg;
  logic                      carr_moving_reg;
  logic                      paper_moving_reg;
  logic                      rib_moving_reg;
  psp_pkg::psp_wheel_state_t wstate_reg;
  logic                      wheel_rdy;
  logic                      carr_rdy;
  logic                      paper_rdy;
  logic                      take_wheel;
  logic                      take_carr;
  logic                      take_paper;
  logic                      take_rib;
  logic                      issue_wheel;
  logic                      issue_carr;
  logic                      issue_paper;
  logic                      issue_rib;
  logic                      all_rest;
  logic                      ps_ribbon;
  logic [`PSP_UNITS_W-1:0]   rib_code;

  // ready means can take a command now
  assign wheel_rdy  = ~fault_reg & ~wheel_pend_reg & (wstate_reg == psp_pkg::PSP_W_IDLE)
                      & ~rib_pend_reg & ~rib_moving_reg;
  assign carr_rdy   = ~fault_reg & ~carr_pend_reg & ~carr_moving_reg;
  assign paper_rdy  = ~fault_reg & ~paper_pend_reg & ~paper_moving_reg;

  // strobe while not ready is dropped
  assign take_wheel = selected & stb_rise[`PSP_STB_WHEEL]  & wheel_rdy;
  assign take_carr  = selected & stb_rise[`PSP_STB_CARR]   & carr_rdy;
  assign take_paper = selected & stb_rise[`PSP_STB_PAPER]  & paper_rdy;
  assign take_rib   = selected & stb_rise[`PSP_STB_RIBBON] & wheel_rdy;

  assign ps_ribbon  = ribbon_option_two | strike_force_option;
  assign rib_code   = {1'b0, cmd_word[`PSP_RIB_MSB:`PSP_RIB_LSB]} + `PSP_RIB_OFFSET;

  // carriage and paper wait for a wheel cycle already under way
  // issue as soon as allowed, in arrival order
  assign issue_wheel = wheel_pend_reg & ~fault_reg & (wstate_reg == psp_pkg::PSP_W_IDLE);
  assign issue_carr  = carr_pend_reg & ~fault_reg & (wstate_reg == psp_pkg::PSP_W_IDLE);
  assign issue_paper = paper_pend_reg & ~fault_reg & (wstate_reg == psp_pkg::PSP_W_IDLE);
  assign issue_rib   = rib_pend_reg & ~fault_reg & (wstate_reg == psp_pkg::PSP_W_IDLE);
  assign all_rest    = ~wheel_moving_reg & ~carr_moving_reg & ~paper_moving_reg;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wheel_pend_reg <= 1'b0;
      carr_pend_reg  <= 1'b0;
      paper_pend_reg <= 1'b0;
      rib_pend_reg   <= 1'b0;
      wheel_hold_reg <= '0;
      carr_hold_reg  <= '0;
      paper_hold_reg <= '0;
      rib_hold_reg   <= '0;
    end else if (fault_reg) begin
      wheel_pend_reg <= 1'b0;
      carr_pend_reg  <= 1'b0;
      paper_pend_reg <= 1'b0;
      rib_pend_reg   <= 1'b0;
    end else begin
      wheel_pend_reg <= take_wheel | (wheel_pend_reg & ~issue_wheel);
      carr_pend_reg  <= take_carr  | (carr_pend_reg  & ~issue_carr);
      paper_pend_reg <= take_paper | (paper_pend_reg & ~issue_paper);
      rib_pend_reg   <= take_rib   | (rib_pend_reg   & ~issue_rib);
      if (take_wheel) begin
        wheel_hold_reg <= cmd_word[`PSP_WHEEL_W-1:0];
      end
      if (take_carr) begin
        carr_hold_reg <= cmd_word;
      end
      if (take_paper) begin
        paper_hold_reg <= cmd_word;
      end
      if (take_rib) begin
        rib_hold_reg <= ps_ribbon ? rib_code : FIXED_RIB_UNITS;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Motion tracking, a new start wins over a coinciding done

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wheel_moving_reg <= 1'b0;
      carr_moving_reg  <= 1'b0;
      paper_moving_reg <= 1'b0;
      rib_moving_reg   <= 1'b0;
    end else if (reinit_rise) begin
      wheel_moving_reg <= 1'b0;
      carr_moving_reg  <= 1'b0;
      paper_moving_reg <= 1'b0;
      rib_moving_reg   <= 1'b0;
    end else begin
      wheel_moving_reg <= issue_wheel | (wheel_moving_reg & ~wheel_done);
      carr_moving_reg  <= issue_carr  | (carr_moving_reg  & ~carr_done);
      paper_moving_reg <= issue_paper | (paper_moving_reg & ~paper_done);
      rib_moving_reg   <= issue_rib   | (rib_moving_reg   & ~ribbon_done);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Print wheel cycle: motion, then strike at rest

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wstate_reg <= psp_pkg::PSP_W_IDLE;
    end else if (fault_reg) begin
      wstate_reg <= psp_pkg::PSP_W_IDLE;
    end else begin
      case (wstate_reg)
        psp_pkg::PSP_W_IDLE: begin
          if (issue_wheel) begin
            wstate_reg <= psp_pkg::PSP_W_MOVE;
          end
        end
        psp_pkg::PSP_W_MOVE: begin
          if (all_rest) begin
            wstate_reg <= psp_pkg::PSP_W_STRIKE;
          end
        end
        psp_pkg::PSP_W_STRIKE: begin
          if (hammer_done) begin
            wstate_reg <= psp_pkg::PSP_W_IDLE;
          end
        end
        default: begin
          wstate_reg <= psp_pkg::PSP_W_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mechanism outputs

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wheel_go     <= 1'b0;
      carr_go      <= 1'b0;
      paper_go     <= 1'b0;
      ribbon_go    <= 1'b0;
      hammer_fire  <= 1'b0;
      wheel_pos    <= '0;
      carr_cmd     <= '0;
      paper_cmd    <= '0;
      ribbon_units <= '0;
      ribbon_raise <= 1'b0;
    end else begin
      wheel_go     <= issue_wheel;
      carr_go      <= issue_carr;
      paper_go     <= issue_paper;
      ribbon_go    <= issue_rib;
      hammer_fire  <= ~fault_reg & (wstate_reg == psp_pkg::PSP_W_MOVE) & all_rest;
      ribbon_raise <= ~raise_s;
      if (issue_wheel) begin
        wheel_pos <= wheel_hold_reg;
      end
      if (issue_carr) begin
        carr_cmd <= carr_hold_reg;
      end
      if (issue_paper) begin
        paper_cmd <= paper_hold_reg;
      end
      if (issue_rib) begin
        ribbon_units <= rib_hold_reg;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Host status pins, low means true; ready pins released high when deselected

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      printer_ready_n  <= 1'b1;
      carriage_ready_n <= 1'b1;
      paper_ready_n    <= 1'b1;
      wheel_ready_n    <= 1'b1;
      option_ready_n   <= 1'b1;
    end else begin
      printer_ready_n  <= ~(selected & power_good);
      carriage_ready_n <= ~(selected & carr_rdy);
      paper_ready_n    <= ~(selected & paper_rdy);
      wheel_ready_n    <= ~(selected & wheel_rdy);
      option_ready_n   <= ~(selected & ~option_busy);
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      fault_n            <= 1'b1;
      paper_empty_n      <= 1'b1;
      lid_open_n         <= 1'b1;
      ribbon_exhausted_n <= 1'b1;
    end else begin
      fault_n            <= ~fault_reg;
      paper_empty_n      <= ~(paper_sensor_fitted & paper_out);
      lid_open_n         <= ~(cover_switch_fitted & cover_open);
      ribbon_exhausted_n <= ~(ribbon_sensor_fitted & ribbon_exhausted_flag);
    end
  end

endmodule : psp_port

// [dv/psp_port_chk.sv]
`timescale 1ns/1ps
`include "psp_params.svh"
module psp_port_chk #(
  parameter logic [`PSP_UNITS_W-1:0] FIXED_RIB_UNITS = `PSP_RIB_FIXED
) (
  input wire logic                    mclk,
  input wire logic                    rst,
  input wire logic                    select_n,
  input wire logic                    reinit_n,
  input wire logic                    printer_ready_n,
  input wire logic                    carriage_ready_n,
  input wire logic                    paper_ready_n,
  input wire logic                    wheel_ready_n,
  input wire logic                    option_ready_n,
  input wire logic                    fault_n,
  input wire logic                    paper_empty_n,
  input wire logic                    lid_open_n,
  input wire logic                    ribbon_exhausted_n,
  input wire logic                    power_good,
  input wire logic                    ribbon_option_two,
  input wire logic                    strike_force_option,
  input wire logic                    paper_sensor_fitted,
  input wire logic                    cover_switch_fitted,
  input wire logic                    ribbon_sensor_fitted,
  input wire logic                    paper_out,
  input wire logic                    cover_open,
  input wire logic                    ribbon_exhausted_flag,
  input wire logic                    option_busy,
  input wire logic                    wheel_go,
  input wire logic                    wheel_done,
  input wire logic                    carr_go,
  input wire logic                    carr_done,
  input wire logic                    paper_go,
  input wire logic                    paper_done,
  input wire logic                    ribbon_go,
  input wire logic [`PSP_UNITS_W-1:0] ribbon_units,
  input wire logic                    hammer_fire,
  input wire logic                    hammer_done,
  input wire logic                    motion_fail,
  input wire logic                    restore_go
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////////
  // Motion outstanding and strike in progress, from the mechanism handshake
  logic w_busy_reg, c_busy_reg, p_busy_reg, strike_reg;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      {w_busy_reg, c_busy_reg, p_busy_reg, strike_reg} <= 4'h0;
    end else begin
      w_busy_reg <= (w_busy_reg | wheel_go) & ~wheel_done & ~restore_go;
      c_busy_reg <= (c_busy_reg | carr_go) & ~carr_done & ~restore_go;
      p_busy_reg <= (p_busy_reg | paper_go) & ~paper_done & ~restore_go;
      strike_reg <= (strike_reg | hammer_fire) & ~hammer_done;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  property p_desel; $past(select_n, 3) |-> {printer_ready_n, carriage_ready_n,
    paper_ready_n, wheel_ready_n, option_ready_n} == 5'h1f; endproperty
  a_desel: assert property (p_desel) else $error("ready driven while deselected");
  property p_power; !$past(select_n, 3) |-> printer_ready_n == !$past(power_good)
    && option_ready_n == $past(option_busy); endproperty
  a_power: assert property (p_power) else $error("printer or option ready wrong");
  property p_fail; motion_fail |-> ##2 (!fault_n && carriage_ready_n && paper_ready_n
    && wheel_ready_n); endproperty
  a_fail: assert property (p_fail) else $error("failure not reported");
  property p_latch; $rose(fault_n) |-> !$past(reinit_n, 4) || !$past(reinit_n, 5)
    || !$past(reinit_n, 6); endproperty
  a_latch: assert property (p_latch) else $error("fault cleared without reinit");
  property p_clr; $fell(reinit_n) |-> ##[1:30] fault_n; endproperty
  a_clr: assert property (p_clr) else $error("fault held too long");
  property p_busy; (carr_go |=> carriage_ready_n) and (paper_go |=> paper_ready_n)
    and (wheel_go |=> wheel_ready_n); endproperty
  a_busy: assert property (p_busy) else $error("ready low while command held");
  property p_rib; ribbon_go |=> wheel_ready_n; endproperty
  a_rib: assert property (p_rib) else $error("wheel ready during ribbon");
  property p_fixed; ribbon_go && !ribbon_option_two && !strike_force_option
    |-> ribbon_units == FIXED_RIB_UNITS; endproperty
  a_fixed: assert property (p_fixed) else $error("ribbon units without option");
  property p_rest; hammer_fire |-> !(w_busy_reg || c_busy_reg || p_busy_reg); endproperty
  a_rest: assert property (p_rest) else $error("hammer fired during motion");
  property p_defer; strike_reg |-> !(wheel_go || carr_go || paper_go); endproperty
  a_defer: assert property (p_defer) else $error("motion during strike");
  property p_stat; 1 |=> {paper_empty_n, lid_open_n, ribbon_exhausted_n} ==
    ~$past({paper_sensor_fitted & paper_out, cover_switch_fitted & cover_open,
    ribbon_sensor_fitted & ribbon_exhausted_flag}); endproperty
  a_stat: assert property (p_stat) else $error("status pin wrong");
endmodule : psp_port_chk

bind psp_port psp_port_chk #(.FIXED_RIB_UNITS(FIXED_RIB_UNITS)) chk (.*);

// [dv/psp_host_model.sv]
`timescale 1ns/1ps
// Mechanism stand-in: done pulse a set number of cycles after go
module psp_resp (
  input  wire logic       mclk,
  input  wire logic       go,
  input  wire logic [7:0] dly,
  output logic            done = 1'b0
);
  logic [7:0] cnt_reg = 8'h00;
  always @(posedge mclk) begin
    done <= (cnt_reg == 8'h01);
    cnt_reg <= go ? dly : cnt_reg - {7'h00, cnt_reg != 8'h00};
  end
endmodule : psp_resp

module psp_host_model (
  input  wire logic  mclk,
  input  wire logic  [3:0] lane_ready_n,
  input  wire logic  fault_n,
  output logic [3:0]  strobe_n = 4'hf,
  output logic [11:0] data_n = 12'hfff,
  output logic        select_n = 1'b1,
  output logic        ribbon_raise_n = 1'b1,
  output logic        reinit_n = 1'b1
);
  task automatic sel(input logic v);
    @(negedge mclk);
    select_n = v;
  endtask : sel
  task automatic send(input int fn, input logic [11:0] word, input bit wt, output bit ok);
    int i;
    ok = 1'b0;
    for (i = 0; wt && i < 400 && lane_ready_n[fn] !== 1'b0; i++) @(negedge mclk);
    if (wt && lane_ready_n[fn] !== 1'b0) return;
    data_n = ~word;
    strobe_n[fn] = 1'b0;
    for (i = 0; i < 8 && !ok; i++) begin
      @(negedge mclk);
      ok = (lane_ready_n[fn] === 1'b1);
    end
    strobe_n[fn] = 1'b1;
    // Released lines float to the pull-up
    data_n = 12'hfff;
    repeat (96) @(negedge mclk);
  endtask : send
  // Lift hold kept short: the full pulse is too long to simulate
  task automatic lift(input logic v);
    @(negedge mclk);
    if (lane_ready_n[0] === 1'b0 && strobe_n[0]) ribbon_raise_n = ~v;
  endtask : lift
  task automatic restore(output int cyc);
    reinit_n = 1'b0;
    for (cyc = 0; cyc < 30 && fault_n !== 1'b1; cyc++) @(negedge mclk);
    repeat (8) @(negedge mclk);
    reinit_n = 1'b1;
  endtask : restore
endmodule : psp_host_model

// [dv/test_psp_port.sv]
`timescale 1ns/1ps
`include "psp_params.svh"
module test_psp_port;
  logic        mclk = 1'b0, rst = 1'b1, power_good = 1'b1, option_busy = 1'b0;
  logic        ribbon_option_two = 1'b0, strike_force_option = 1'b0, motion_fail = 1'b0;
  logic        paper_sensor_fitted = 1'b0, cover_switch_fitted = 1'b0, ribbon_sensor_fitted = 1'b0;
  logic        paper_out = 1'b0, cover_open = 1'b0, ribbon_exhausted_flag = 1'b0;
  logic [3:0]  strobe_n, ribbon_units;
  logic [11:0] data_n, carr_cmd, paper_cmd;
  logic [6:0]  wheel_pos;
  logic        select_n, ribbon_raise_n, reinit_n, ribbon_raise, fault_n;
  logic        printer_ready_n, carriage_ready_n, paper_ready_n, wheel_ready_n, option_ready_n;
  logic        paper_empty_n, lid_open_n, ribbon_exhausted_n;
  logic        wheel_go, carr_go, paper_go, ribbon_go, hammer_fire, restore_go;
  logic        wheel_done, carr_done, paper_done, ribbon_done, hammer_done;
  logic [7:0]  dly [5] = '{8'd20, 8'd150, 8'd30, 8'd10, 8'd5};
  int          mismatches = 0, checked = 0, n_ev [6] = '{0, 0, 0, 0, 0, 0};
  realtime     t_ev [6];
  bit          ok;
  wire [3:0]   lane_ready_n = {wheel_ready_n, paper_ready_n, carriage_ready_n, wheel_ready_n};
  wire [4:0]   rdy = {printer_ready_n, carriage_ready_n, paper_ready_n, wheel_ready_n,
                      option_ready_n};
  wire [5:0]   ev = {restore_go, hammer_fire, ribbon_go, paper_go, carr_go, wheel_go};
  ////////////////////////////////////////////////////////////////////////////////
  psp_port uut (.*);
  psp_host_model host (.*);
  psp_resp r_w (.mclk(mclk), .go(wheel_go), .dly(dly[0]), .done(wheel_done));
  psp_resp r_c (.mclk(mclk), .go(carr_go), .dly(dly[1]), .done(carr_done));
  psp_resp r_p (.mclk(mclk), .go(paper_go), .dly(dly[2]), .done(paper_done));
  psp_resp r_r (.mclk(mclk), .go(ribbon_go), .dly(dly[3]), .done(ribbon_done));
  psp_resp r_h (.mclk(mclk), .go(hammer_fire), .dly(dly[4]), .done(hammer_done));
  initial forever #2 mclk = ~mclk;
  always @(posedge mclk) for (int k = 0; k < 6; k++) if (ev[k]) begin
    n_ev[k]++;
    t_ev[k] = $realtime;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic complete_run();
    $display("mismatches=%0d checked=%0d", mismatches, checked);
    if (mismatches == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : complete_run
  // Bounded wait for a new event of kind k
  task automatic wait_ev(input int k, input int n0);
    for (int i = 0; i < 600 && n_ev[k] <= n0; i++) @(negedge mclk);
    if (n_ev[k] <= n0) begin
      mismatches++;
      complete_run();
    end
  endtask : wait_ev
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_ready();
    check(rdy, 5'h1f);
    host.sel(1'b0);
    repeat (10) @(negedge mclk);
    check(rdy, 5'h00);
    power_good = 1'b0;
    option_busy = 1'b1;
    repeat (4) @(negedge mclk);
    check(rdy, 5'h11);
    power_good = 1'b1;
    option_busy = 1'b0;
    host.lift(1'b1);
    repeat (3) @(negedge mclk);
    check(ribbon_raise, 1'b1);
    host.lift(1'b0);
  endtask : t_ready
  task automatic t_status();
    for (int m = 0; m < 64; m++) begin
      {paper_sensor_fitted, cover_switch_fitted, ribbon_sensor_fitted, paper_out,
       cover_open, ribbon_exhausted_flag} = m[5:0];
      repeat (2) @(negedge mclk);
      check({paper_empty_n, lid_open_n, ribbon_exhausted_n} ^ 3'h7, m[5:3] & m[2:0]);
    end
    {paper_sensor_fitted, cover_switch_fitted, ribbon_sensor_fitted} = 3'h0;
  endtask : t_status
  task automatic t_cmd();
    host.data_n = 12'ha5a;
    repeat (20) @(negedge mclk);
    host.data_n = 12'hfff;
    check(n_ev[1] + n_ev[2], 0);
    host.send(1, 12'h9c3, 1'b1, ok);
    check(ok, 1'b1);
    check(carr_cmd, 12'h9c3);
    host.send(2, 12'h3c9, 1'b1, ok);
    check(paper_cmd, 12'h3c9);
    check({n_ev[1][3:0], n_ev[2][3:0]}, 8'h11);
  endtask : t_cmd
  task automatic t_ribbon();
    // Half-step advance is the host's pick; codes 0-6 swept, plus fixed advance
    for (int c = 0; c < 9; c++) begin
      ribbon_option_two = (c < 7);
      strike_force_option = (c == 7);
      host.send(3, {1'b0, 3'(c % 7), 8'h00}, 1'b1, ok);
      check(ok, 1'b1);
      check(ribbon_units, c == 8 ? `PSP_RIB_FIXED : c % 7 + 2);
    end
  endtask : t_ribbon
  task automatic t_order();
    int f;
    f = n_ev[4];
    host.send(1, 12'h010, 1'b1, ok);
    host.send(0, 12'h025, 1'b1, ok);
    wait_ev(4, f);
    check(t_ev[0] < t_ev[1] + 600.0, 1'b1);
    check(t_ev[4] > t_ev[1] + 600.0, 1'b1);
    check(wheel_pos, 7'h25);
    dly[0] = 8'd200;
    f = n_ev[1];
    host.send(0, 12'h033, 1'b1, ok);
    host.send(1, 12'h020, 1'b1, ok);
    wait_ev(1, f);
    check(t_ev[1] > t_ev[4], 1'b1);
    dly[0] = 8'd20;
  endtask : t_order
  task automatic t_refuse();
    int c;
    c = n_ev[1];
    host.send(1, 12'h001, 1'b1, ok);
    host.send(1, 12'h002, 1'b0, ok);
    repeat (100) @(negedge mclk);
    check(n_ev[1], c + 1);
    check(carr_cmd, 12'h001);
  endtask : t_refuse
  task automatic t_fault();
    int c, r, cyc;
    c = n_ev[1];
    r = n_ev[5];
    motion_fail = 1'b1;
    @(negedge mclk);
    motion_fail = 1'b0;
    repeat (3) @(negedge mclk);
    check({fault_n, carriage_ready_n, paper_ready_n, wheel_ready_n}, 4'h7);
    host.send(1, 12'h0ff, 1'b0, ok);
    repeat (50) @(negedge mclk);
    check(fault_n, 1'b0);
    check(n_ev[1], c);
    host.restore(cyc);
    check(cyc < 30, 1'b1);
    check(n_ev[5], r + 1);
    repeat (4) @(negedge mclk);
    check(rdy, 5'h00);
  endtask : t_fault
  task automatic t_desel();
    int c;
    host.sel(1'b1);
    repeat (3) @(negedge mclk);
    check(rdy, 5'h1f);
    c = n_ev[1];
    host.send(1, 12'h004, 1'b0, ok);
    check(n_ev[1], c);
  endtask : t_desel
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(negedge mclk);
    rst = 1'b0;
    t_ready();
    t_status();
    t_cmd();
    t_ribbon();
    t_order();
    t_refuse();
    t_fault();
    t_desel();
    complete_run();
  end
endmodule : test_psp_port
